/* refsw_pkg.sv */
// Package: register map, field layout, reset values and timing of the reference switchover block
`default_nettype none
package refsw_pkg;
  // Timing
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned CLK_PERIOD_FS = 4000000;
  localparam int unsigned MS_TIME_NS = 1000000;
  localparam int unsigned MS_CYCLES_DOC = MS_TIME_NS / CLK_PERIOD_NS;
  // Register indices; byte address is four times the index
  localparam logic [13:0] IDX_IO_UPDATE = 14'h0005;
  localparam logic [13:0] IDX_FREERUN_WORD = 14'h0300;
  localparam logic [13:0] IDX_PROFILE_BASE = 14'h0700;
  localparam logic [13:0] IDX_PROFILE_MASK = 14'h0047;
  localparam logic [13:0] IDX_LOOP_MODE = 14'h0A01;
  localparam logic [13:0] IDX_VALID_FORCE = 14'h0A0B;
  localparam logic [13:0] IDX_INVALID_FORCE = 14'h0A0D;
  localparam logic [13:0] IDX_STATUS = 14'h0D0A;
  localparam logic [13:0] IDX_EVENTS = 14'h0D0B;
  // Profile word layout; bit 6 of the index picks the profile
  localparam int unsigned PROF_SEL_BIT = 6;
  localparam logic [2:0] PROF_PERIOD_LO = 3'h0;
  localparam logic [2:0] PROF_PERIOD_HI = 3'h1;
  localparam logic [2:0] PROF_INNER = 3'h2;
  localparam logic [2:0] PROF_OUTER = 3'h3;
  localparam logic [2:0] PROF_VTIME = 3'h4;
  localparam logic [2:0] PROF_PRIO = 3'h5;
  // Loop mode fields
  localparam int unsigned USER_REF_BIT = 0;
  localparam int unsigned MODE_LSB = 2;
  localparam int unsigned MODE_W = 3;
  localparam int unsigned FREERUN_BIT = 5;
  localparam int unsigned HOLDOVER_BIT = 6;
  localparam logic [2:0] MODE_AUTO_REVERT = 3'h0;
  localparam logic [2:0] MODE_AUTO_NONREVERT = 3'h1;
  localparam logic [2:0] MODE_MAN_FALLBACK = 3'h2;
  localparam logic [2:0] MODE_MAN_HOLDOVER = 3'h3;
  localparam logic [2:0] MODE_FULL_MANUAL = 3'h4;
  localparam logic [7:0] LOOP_MODE_RST = 8'h20;
  // Event bits
  localparam int unsigned EV_ACTIVE_BIT = 2;
  typedef struct packed {
    logic [2:0] prio;
    logic [15:0] vtime;
    logic [19:0] outer;
    logic [19:0] inner;
    logic [39:0] period;
  } profile_t;
  localparam profile_t PROFILE_RST = '0;
  typedef enum logic [1:0] {LOOP_FREERUN, LOOP_HOLDOVER, LOOP_TRACK} loop_state_t;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [15:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_t;
endpackage : refsw_pkg
`default_nettype wire

/* ref_period_monitor.sv */
// Period monitor and validation timer for one reference input
`default_nettype none
module ref_period_monitor #(
  parameter int unsigned CW = 20
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic ref_clk,
  input wire logic run,
  input wire logic ms_tick,
  input wire refsw_pkg::profile_t prof,
  output logic fault,
  output logic timer_done
);
  import refsw_pkg::*;

  logic [2:0] sync_q;
  logic [CW-1:0] cnt_q;
  logic fault_q;
  logic done_q;
  logic [15:0] ms_q;

  wire rise = sync_q[1] & ~sync_q[2];
  wire [63:0] meas = 64'(cnt_q) * 64'(CLK_PERIOD_FS);
  wire [63:0] nom = {24'h000000, prof.period};
  wire [63:0] dev = (meas > nom) ? meas - nom : nom - meas;
  // dev > nom/tol, written without a divider
  wire over_outer = (dev * 64'(prof.outer)) > nom;
  wire in_inner = (dev * 64'(prof.inner)) <= nom;
  // A reference that stops toggling never gives a rise; fault it at twice the nominal period
  wire stalled = meas > {nom[62:0], 1'b0};
  wire cnt_max = &cnt_q;

  assign fault = fault_q;
  assign timer_done = done_q;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sync_q <= 3'h0;
    end else begin
      sync_q <= {sync_q[1:0], ref_clk};
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= CW'(1);
      fault_q <= 1'b1;
    end else if (!run) begin
      cnt_q <= CW'(1);
      fault_q <= 1'b1;
    end else if (rise) begin
      cnt_q <= CW'(1);
      if (fault_q && in_inner) begin
        fault_q <= 1'b0;
      end else if (!fault_q && over_outer) begin
        fault_q <= 1'b1;
      end
    end else begin
      if (!cnt_max) begin
        cnt_q <= cnt_q + 1'b1;
      end
      if (stalled) begin
        fault_q <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Validation timer: the first tick may come early, so one extra tick is
  // counted to guarantee the whole timeout
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ms_q <= 16'h0000;
      done_q <= 1'b0;
    end else if (fault_q || prof.vtime == 16'h0000) begin
      ms_q <= 16'h0000;
      done_q <= 1'b0;
    end else if (ms_tick && !done_q) begin
      if (ms_q == prof.vtime) begin
        done_q <= 1'b1;
      end else begin
        ms_q <= ms_q + 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  fault_clear_a: assert property ($fell(fault_q) |-> $past(rise && in_inner && run))
    else $error("fault cleared without an inner-tolerance measurement");
  fault_set_a: assert property ($rose(fault_q) |-> $past(!run || stalled || (rise && over_outer)))
    else $error("fault raised without cause");
  halt_run_a: assert property (!run [*2] |=> fault_q && !done_q)
    else $error("monitor active before system clock stable");
  timer_full_a: assert property ($rose(done_q) |-> $past(ms_tick) && !$past(fault_q)
    && $past(ms_q) == $past(prof.vtime))
    else $error("validation timer ended early");
endmodule : ref_period_monitor
`default_nettype wire

/* ref_switchover_top.sv */
// Reference monitors, validation and switchover state machine with APB registers
//
// Overview of operation
// - Each reference has its own period monitor
// - Nominal period is 40-bit femtoseconds
// - Tolerances are 20-bit reciprocals of the fractional deviation
// - Faulted clears only within inner tolerance
// - Nonfaulted faults beyond outer tolerance
// - Monitors wait for stable system clock
// - Valid only after full unfaulted timeout
// - Timeout is 16-bit milliseconds
// - Zero timeout needs manual validation
// - Software can force valid or invalid
// - Active reference brings its own profile
// - Three-bit field picks five switchover modes
// - Automatic modes pick highest valid priority
// - Ties prefer first, never force switch
// - Revertive switches up to higher priority
// - Nonrevertive keeps valid current reference
// - Fallback uses user reference while valid
// - Manual holdover enters holdover when invalid
// - Full manual keeps user reference always
// - User bits force holdover or free run
// - Settings apply only on update strobe
`default_nettype none
module ref_switchover_top #(
  parameter int unsigned MS_CYCLES = refsw_pkg::MS_CYCLES_DOC,
  parameter int unsigned CW = 20
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire refsw_pkg::apb_req_t apb_req,
  output refsw_pkg::apb_rsp_t apb_rsp,
  input wire logic [1:0] ref_clk,
  input wire logic sysclk_stable,
  output logic ref_sel,
  output refsw_pkg::loop_state_t loop_state,
  output refsw_pkg::profile_t active_prof,
  output logic [31:0] freerun_word,
  output logic [1:0] ref_valid
);
  import refsw_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // System clock stable and millisecond tick
  logic [1:0] stable_q;
  logic [31:0] div_q;
  logic ms_tick_q;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      stable_q <= 2'h0;
    end else begin
      stable_q <= {stable_q[0], sysclk_stable};
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      div_q <= 32'h00000000;
      ms_tick_q <= 1'b0;
    end else begin
      ms_tick_q <= (div_q == MS_CYCLES - 1);
      div_q <= (div_q == MS_CYCLES - 1) ? 32'h00000000 : div_q + 32'h00000001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // APB decode
  wire [13:0] idx = apb_req.paddr[15:2];
  wire [2:0] sub = idx[2:0];
  wire aligned = apb_req.paddr[1:0] == 2'h0;
  wire setup = apb_req.psel & ~apb_req.penable;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  wire access = apb_req.psel & apb_req.penable & pready_q;
  wire hit_upd = aligned && idx == IDX_IO_UPDATE;
  wire hit_ftw = aligned && idx == IDX_FREERUN_WORD;
  wire hit_loop = aligned && idx == IDX_LOOP_MODE;
  wire hit_vfrc = aligned && idx == IDX_VALID_FORCE;
  wire hit_ifrc = aligned && idx == IDX_INVALID_FORCE;
  wire hit_stat = aligned && idx == IDX_STATUS;
  wire hit_ev = aligned && idx == IDX_EVENTS;
  wire hit_prof = aligned && (idx & ~IDX_PROFILE_MASK) == IDX_PROFILE_BASE && sub <= PROF_PRIO;
  wire hit = hit_upd | hit_ftw | hit_loop | hit_vfrc | hit_ifrc | hit_stat | hit_ev | hit_prof;
  wire wr = access & apb_req.pwrite & ~pslverr_q;
  wire [31:0] wd = apb_req.pwdata;
  wire upd = wr & hit_upd & wd[0];

  ////////////////////////////////////////////////////////////////////////
  // Shadow registers take writes; the working copies follow on update only
  logic [7:0] loop_sh_q;
  logic [7:0] vfrc_sh_q;
  logic [7:0] ifrc_sh_q;
  logic [31:0] ftw_sh_q;
  logic [7:0] loop_q;
  logic [7:0] vfrc_q;
  logic [7:0] ifrc_q;
  logic [31:0] ftw_q;
  logic upd_q;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      loop_sh_q <= LOOP_MODE_RST;
      vfrc_sh_q <= 8'h00;
      ifrc_sh_q <= 8'h00;
      ftw_sh_q <= 32'h00000000;
    end else if (wr) begin
      if (hit_loop) begin
        loop_sh_q <= wd[7:0];
      end
      if (hit_vfrc) begin
        vfrc_sh_q <= wd[7:0];
      end
      if (hit_ifrc) begin
        ifrc_sh_q <= wd[7:0];
      end
      if (hit_ftw) begin
        ftw_sh_q <= wd;
      end
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      loop_q <= LOOP_MODE_RST;
      vfrc_q <= 8'h00;
      ifrc_q <= 8'h00;
      ftw_q <= 32'h00000000;
      upd_q <= 1'b0;
    end else begin
      upd_q <= upd;
      if (upd) begin
        loop_q <= loop_sh_q;
        vfrc_q <= vfrc_sh_q;
        ifrc_q <= ifrc_sh_q;
        ftw_q <= ftw_sh_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Per-reference profile storage and monitor
  profile_t prof_sh [2];
  profile_t prof [2];
  logic [1:0] fault;
  logic [1:0] done;

  for (genvar g = 0; g < 2; g++) begin : g_ref
    profile_t sh_q;
    profile_t act_q;
    wire sel_me = wr && hit_prof && idx[PROF_SEL_BIT] == 1'(g);
    assign prof_sh[g] = sh_q;
    assign prof[g] = act_q;

    always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
        sh_q <= PROFILE_RST;
      end else if (sel_me) begin
        case (sub)
          PROF_PERIOD_LO: sh_q.period[31:0] <= wd;
          PROF_PERIOD_HI: sh_q.period[39:32] <= wd[7:0];
          PROF_INNER: sh_q.inner <= wd[19:0];
          PROF_OUTER: sh_q.outer <= wd[19:0];
          PROF_VTIME: sh_q.vtime <= wd[15:0];
          default: sh_q.prio <= wd[2:0];
        endcase
      end
    end

    // Software is expected not to rewrite the profile in use while tracking
    always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
        act_q <= PROFILE_RST;
      end else if (upd) begin
        act_q <= sh_q;
      end
    end

    ref_period_monitor #(.CW(CW)) u_mon (
      .mclk(mclk),
      .reset_n(reset_n),
      .ref_clk(ref_clk[g]),
      .run(stable_q[1]),
      .ms_tick(ms_tick_q),
      .prof(act_q),
      .fault(fault[g]),
      .timer_done(done[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////
  // Validity with overrides; forcing invalid wins over forcing valid
  wire [1:0] valid_d = ((done & ~fault) | vfrc_q[1:0]) & ~ifrc_q[1:0];
  logic [1:0] valid_q;

  ////////////////////////////////////////////////////////////////////////
  // Switchover decision
  loop_state_t state_q;
  loop_state_t state_d;
  logic sel_q;
  logic sel_d;
  wire [2:0] mode = loop_q[MODE_LSB +: MODE_W];
  wire user = loop_q[USER_REF_BIT];
  wire force_fr = loop_q[FREERUN_BIT];
  wire force_ho = loop_q[HOLDOVER_BIT];
  wire [2:0] prio_cur = prof[sel_q].prio;
  wire [2:0] prio_oth = prof[~sel_q].prio;
  wire any_valid = |valid_q;
  // Equal priority goes to the first reference
  wire best = valid_q[1] && !(valid_q[0] && prof[0].prio >= prof[1].prio);
  wire cur_ok = state_q == LOOP_TRACK && valid_q[sel_q];
  wire oth_up = valid_q[~sel_q] && prio_oth > prio_cur;
  wire no_force = !force_fr && !force_ho;

  always_comb begin
    state_d = LOOP_TRACK;
    sel_d = sel_q;
    if (force_fr) begin
      state_d = LOOP_FREERUN;
    end else if (force_ho) begin
      state_d = LOOP_HOLDOVER;
    end else begin
      unique case (mode)
        MODE_FULL_MANUAL: sel_d = user;
        MODE_MAN_HOLDOVER: begin
          sel_d = user;
          if (!valid_q[user]) begin
            state_d = LOOP_HOLDOVER;
          end
        end
        MODE_MAN_FALLBACK: begin
          if (valid_q[user]) begin
            sel_d = user;
          end else if (any_valid) begin
            sel_d = best;
          end else begin
            state_d = LOOP_HOLDOVER;
          end
        end
        MODE_AUTO_NONREVERT: begin
          if (!cur_ok) begin
            if (any_valid) begin
              sel_d = best;
            end else begin
              state_d = LOOP_HOLDOVER;
            end
          end
        end
        // Revertive; unused codes also land here
        default: begin
          if (!cur_ok || oth_up) begin
            if (any_valid) begin
              sel_d = best;
            end else begin
              state_d = LOOP_HOLDOVER;
            end
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State, outputs and events
  logic [2:0] ev_q;
  profile_t aprof_q;
  wire act_chg = (state_d == LOOP_TRACK) != (state_q == LOOP_TRACK)
    || (state_d == LOOP_TRACK && sel_d != sel_q);
  wire [2:0] ev_set = {act_chg, valid_d ^ valid_q};
  wire [2:0] ev_clr = (wr && hit_ev) ? wd[2:0] : 3'h0;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= LOOP_FREERUN;
      sel_q <= 1'b0;
      valid_q <= 2'h0;
      aprof_q <= PROFILE_RST;
      ev_q <= 3'h0;
    end else begin
      state_q <= state_d;
      sel_q <= sel_d;
      valid_q <= valid_d;
      aprof_q <= prof[sel_d];
      ev_q <= (ev_q & ~ev_clr) | ev_set;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read path and APB answer, one wait-free access phase
  profile_t prd;
  assign prd = prof_sh[idx[PROF_SEL_BIT]];
  wire [31:0] prof_rd = sub == PROF_PERIOD_LO ? prd.period[31:0]
    : sub == PROF_PERIOD_HI ? {24'h000000, prd.period[39:32]}
    : sub == PROF_INNER ? {12'h000, prd.inner}
    : sub == PROF_OUTER ? {12'h000, prd.outer}
    : sub == PROF_VTIME ? {16'h0000, prd.vtime}
    : {29'h0, prd.prio};
  wire [7:0] status = {stable_q[1], state_q == LOOP_FREERUN, state_q == LOOP_HOLDOVER,
    sel_q, valid_q, fault};
  wire [31:0] rdata = hit_loop ? {24'h000000, loop_sh_q}
    : hit_vfrc ? {24'h000000, vfrc_sh_q}
    : hit_ifrc ? {24'h000000, ifrc_sh_q}
    : hit_ftw ? ftw_sh_q
    : hit_stat ? {24'h000000, status}
    : hit_ev ? {29'h0, ev_q}
    : hit_prof ? prof_rd
    : 32'h00000000;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end else begin
      pready_q <= setup;
      pslverr_q <= setup & ~hit;
      if (setup) begin
        prdata_q <= apb_req.pwrite ? 32'h00000000 : rdata;
      end
    end
  end

  assign apb_rsp = '{prdata: prdata_q, pready: pready_q, pslverr: pslverr_q};
  assign ref_sel = sel_q;
  assign loop_state = state_q;
  assign active_prof = aprof_q;
  assign freerun_word = ftw_q;
  assign ref_valid = valid_q;

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  update_gate_a: assert property (!upd_q |-> $stable(loop_q) && $stable(vfrc_q))
    else $error("loop settings changed without update");
  force_freerun_a: assert property (force_fr |=> state_q == LOOP_FREERUN)
    else $error("free run not forced");
  revert_up_a: assert property (no_force && mode == MODE_AUTO_REVERT && cur_ok && oth_up
    |=> sel_q != $past(sel_q) && state_q == LOOP_TRACK)
    else $error("revertive mode missed higher priority");
  tie_stay_a: assert property (no_force && mode == MODE_AUTO_REVERT && cur_ok && prio_cur == prio_oth
    |=> $stable(sel_q))
    else $error("tie caused a switch");
  nonrevert_a: assert property (no_force && mode == MODE_AUTO_NONREVERT && cur_ok
    |=> $stable(sel_q) && state_q == LOOP_TRACK)
    else $error("nonrevertive mode left valid reference");
  man_hold_a: assert property (no_force && mode == MODE_MAN_HOLDOVER && !valid_q[user]
    |=> state_q == LOOP_HOLDOVER)
    else $error("manual holdover not entered");
  full_manual_a: assert property (no_force && mode == MODE_FULL_MANUAL
    |=> sel_q == $past(user) && state_q == LOOP_TRACK)
    else $error("full manual left user reference");
  auto_hold_a: assert property (no_force && mode <= MODE_AUTO_NONREVERT && !any_valid
    |=> state_q == LOOP_HOLDOVER)
    else $error("no holdover with no valid reference");
  valid_event_a: assert property ($changed(valid_q) |-> (ev_q[1:0] & (valid_q ^ $past(valid_q))) != 2'h0)
    else $error("validity change not flagged");
endmodule : ref_switchover_top
`default_nettype wire

/* ref_clock_source.sv */
// Reference clock source model: steady clock of programmable half period, low while stopped
`default_nettype none
module ref_clock_source (
  input wire logic run,
  input wire logic [31:0] half_ns,
  output logic ref_clk
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    ref_clk = 1'b0;
    forever begin
      wait (run === 1'b1);
      // Offset keeps source edges off the mclk edges, so counts do not hinge on a race
      #1.3;
      while (run === 1'b1) begin
        ref_clk = ~ref_clk;
        #(half_ns);
      end
      // Receiver pull-down takes a stopped input low
      ref_clk = 1'b0;
    end
  end
endmodule : ref_clock_source
`default_nettype wire

/* testbench.sv */
// Self-checking bench for the reference monitor and switchover block
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import refsw_pkg::*;
  localparam int unsigned MS = 10;
  localparam logic [39:0] NOM_FS = 40'h0002625A00;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic sysclk_stable = 1'b0;
  logic [1:0] run = 2'b11;
  int unsigned half_ns [2] = '{20, 20};
  apb_req_t req = '0;
  apb_rsp_t rsp;
  logic [1:0] ref_clk;
  logic ref_sel;
  loop_state_t loop_state;
  profile_t active_prof;
  logic [31:0] freerun_word;
  logic [1:0] ref_valid;
  int fails = 0;
  int checks_done = 0;
  int waited;
  logic [31:0] rd;
  logic err;
  logic [31:0] fw;
  logic [2:0] pr;

  always #2 mclk = ~mclk;

  ref_switchover_top #(.MS_CYCLES(MS), .CW(20)) ref_switchover_top_i (
    .mclk(mclk),
    .reset_n(reset_n),
    .apb_req(req),
    .apb_rsp(rsp),
    .ref_clk(ref_clk),
    .sysclk_stable(sysclk_stable),
    .ref_sel(ref_sel),
    .loop_state(loop_state),
    .active_prof(active_prof),
    .freerun_word(freerun_word),
    .ref_valid(ref_valid)
  );
  for (genvar g = 0; g < 2; g++) begin : src
    ref_clock_source ref_clock_source_i (
      .run(run[g]),
      .half_ns(half_ns[g]),
      .ref_clk(ref_clk[g])
    );
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    if (fails == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude

  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %0h, seen %0h", what, exp, seen);
    end
  endtask : chk

  // Setup, then access held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [13:0] idx, input logic [31:0] wd);
    @(posedge mclk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: {idx, 2'b00}, pwdata: wd};
    @(posedge mclk);
    req.penable <= 1'b1;
    // Answer is read at the rising edge, before that edge moves it; the watchdog ends a hang
    do begin
      @(posedge mclk);
    end while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask : apb

  task automatic upd(input logic [13:0] idx, input logic [31:0] wd);
    apb(1'b1, idx, wd);
    apb(1'b1, IDX_IO_UPDATE, 32'h1);
  endtask : upd

  task automatic prof(input logic r, input logic [2:0] k, input logic [31:0] wd);
    apb(1'b1, IDX_PROFILE_BASE | (14'(r) << PROF_SEL_BIT) | 14'(k), wd);
  endtask : prof

  // Selection only matters while tracking; in holdover the selected input is not judged
  task automatic expect_out(input logic [1:0] v, input logic s, input loop_state_t l);
    waited = 0;
    @(negedge mclk);
    while (!(ref_valid === v && loop_state === l && (l != LOOP_TRACK || ref_sel === s)) && waited < 3000) begin
      @(negedge mclk);
      waited++;
    end
    chk("ref_valid", 64'(ref_valid), 64'(v));
    chk("loop_state", 64'(loop_state), 64'(l));
    if (l == LOOP_TRACK) chk("ref_sel", 64'(ref_sel), 64'(s));
  endtask : expect_out

  function automatic logic pick(input logic [2:0] p0, input logic [2:0] p1, input logic [1:0] v);
    if (v == 2'b10) return 1'b1;
    return v == 2'b11 && p1 > p0;
  endfunction : pick

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    #80000;
    fails++;
    conclude();
  end

  initial begin
    void'($urandom(32'h3632));
    repeat (3) @(posedge mclk);
    reset_n <= 1'b1;
    expect_out(2'b00, 1'b0, LOOP_FREERUN);
    apb(1'b0, IDX_LOOP_MODE, 32'h0);
    chk("loop mode reset", 64'(rd), 64'(LOOP_MODE_RST));
    apb(1'b0, 14'h0001, 32'h0);
    chk("unmapped error", 64'(err), 64'h1);
    chk("unmapped data", 64'(rd), 64'h0);
    pr = 3'($urandom_range(0, 6));
    fw = $urandom;
    for (int r = 0; r < 2; r++) begin
      prof(r[0], PROF_PERIOD_LO, NOM_FS[31:0]);
      prof(r[0], PROF_PERIOD_HI, 32'(NOM_FS[39:32]));
      prof(r[0], PROF_INNER, 32'h28);
      prof(r[0], PROF_OUTER, 32'h14);
      prof(r[0], PROF_VTIME, 32'h2);
      prof(r[0], PROF_PRIO, 32'(pr));
    end
    apb(1'b1, IDX_FREERUN_WORD, fw);
    @(negedge mclk);
    chk("word before update", 64'(freerun_word), 64'h0);
    apb(1'b1, IDX_IO_UPDATE, 32'h1);
    repeat (200) @(negedge mclk);
    expect_out(2'b00, 1'b0, LOOP_FREERUN);
    chk("freerun_word", 64'(freerun_word), 64'(fw));
    apb(1'b0, IDX_FREERUN_WORD, 32'h0);
    chk("freerun readback", 64'(rd), 64'(fw));
    // Leaving free run with nothing valid must land in holdover
    upd(IDX_LOOP_MODE, 32'h00);
    expect_out(2'b00, 1'b0, LOOP_HOLDOVER);
    @(posedge mclk);
    sysclk_stable <= 1'b1;
    expect_out(2'b11, pick(pr, pr, 2'b11), LOOP_TRACK);
    chk("validation delay", 64'(waited >= 2 * MS), 64'h1);
    apb(1'b0, IDX_EVENTS, 32'h0);
    chk("validity events", 64'(rd[1:0]), 64'h3);
    apb(1'b1, IDX_EVENTS, 32'h7);
    apb(1'b0, IDX_EVENTS, 32'h0);
    chk("events cleared", 64'(rd[1:0]), 64'h0);
    // Profile of the second input is only touched while it is invalidated
    upd(IDX_INVALID_FORCE, 32'h2);
    expect_out(2'b01, 1'b0, LOOP_TRACK);
    prof(1'b1, PROF_PRIO, 32'(pr + 3'h1));
    upd(IDX_INVALID_FORCE, 32'h0);
    expect_out(2'b11, pick(pr, pr + 3'h1, 2'b11), LOOP_TRACK);
    chk("active prio", 64'(active_prof.prio), 64'(pr + 3'h1));
    chk("active period", 64'(active_prof.period), 64'(NOM_FS));
    apb(1'b0, IDX_EVENTS, 32'h0);
    chk("active events", 64'(rd[2:1]), 64'h3);
    upd(IDX_LOOP_MODE, 32'h04);
    half_ns[1] = 24;
    expect_out(2'b01, 1'b0, LOOP_TRACK);
    half_ns[1] = 20;
    expect_out(2'b11, 1'b0, LOOP_TRACK);
    repeat (100) @(negedge mclk);
    expect_out(2'b11, 1'b0, LOOP_TRACK);
    upd(IDX_INVALID_FORCE, 32'h3);
    expect_out(2'b00, 1'b0, LOOP_HOLDOVER);
    upd(IDX_LOOP_MODE, 32'h11);
    expect_out(2'b00, 1'b1, LOOP_TRACK);
    upd(IDX_LOOP_MODE, 32'h0C);
    expect_out(2'b00, 1'b0, LOOP_HOLDOVER);
    upd(IDX_INVALID_FORCE, 32'h0);
    expect_out(2'b11, 1'b0, LOOP_TRACK);
    upd(IDX_INVALID_FORCE, 32'h1);
    expect_out(2'b10, 1'b0, LOOP_HOLDOVER);
    upd(IDX_LOOP_MODE, 32'h08);
    expect_out(2'b10, pick(pr, pr + 3'h1, 2'b10), LOOP_TRACK);
    upd(IDX_INVALID_FORCE, 32'h0);
    expect_out(2'b11, 1'b0, LOOP_TRACK);
    // A zero timeout leaves a recovered input invalid until software validates it
    run[1] <= 1'b0;
    expect_out(2'b01, 1'b0, LOOP_TRACK);
    prof(1'b1, PROF_VTIME, 32'h0);
    upd(IDX_VALID_FORCE, 32'h0);
    run[1] <= 1'b1;
    repeat (200) @(negedge mclk);
    expect_out(2'b01, 1'b0, LOOP_TRACK);
    upd(IDX_VALID_FORCE, 32'h2);
    expect_out(2'b11, 1'b0, LOOP_TRACK);
    upd(IDX_LOOP_MODE, 32'h48);
    expect_out(2'b11, 1'b0, LOOP_HOLDOVER);
    upd(IDX_LOOP_MODE, 32'h68);
    expect_out(2'b11, 1'b0, LOOP_FREERUN);
    conclude();
  end
endmodule : testbench
`default_nettype wire
